// File: verilog/hcfg_top.sv
// Haptic dissipation-time and loop configuration registers over I2C
// Behaviour
// [R1] Bits 1-0 of the back-EMF timing register hold a RW dissipation code, reset 1.
// [R2] For a resonant actuator the code grows to four bits with the top two from the 0x1F bank.
// [R3] For a rotating mass, codes 0-3 mean 45, 75, 150 and 225 us.
// [R4] For a resonant actuator, codes 0-15 mean 15 to 285 us per the fixed table.
// [R5] The loop-and-input register sits at 0x1D with all eight bits RW.
// [R6] Its fields are noise gate 7-6, open loop 5, supply off 4, format 3, update rate 2, input type 1.
// [R7] Noise-gate codes mean off, 2, 4 and 8 percent, reset code 2.
// [R8] A rotating mass runs closed loop with the open-loop bit 0, open loop with 1.
// [R9] Live-playback data is signed with the format bit 0, unsigned with 1.
`default_nettype none
module hcfg_top
  import hcfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
  input wire logic clk, // 100 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic scl_i, // I2C clock pin level
  input wire logic sda_i, // I2C data pin level
  output logic sda_o, // I2C data drive level, always low
  output logic sda_oe, // High while pulling data low
  input wire logic actuator_type_select, // 0 rotating mass, 1 resonant
  input wire logic [1:0] idiss_upper, // Upper code bits from 0x1F bank
  output logic [7:0] back_emf_timing, // Back-EMF timing register
  output logic [7:0] loop_input_cfg, // Loop-and-input register
  output logic [1:0] noise_gate_level, // Noise-gate code
  output logic [3:0] noise_gate_pct, // Noise-gate threshold percent
  output logic rotating_mass_loop_open, // Open-loop select bit
  output logic closed_loop_drive, // Rotating mass in closed loop
  output logic supply_correction_off, // Supply compensation disabled
  output logic live_playback_sign_format, // Format bit as stored
  output logic live_playback_signed, // Playback data is signed
  output logic resonant_update_rate, // Resonant update mode bit
  output logic input_type_select, // Input type select bit
  output logic [3:0] idiss_code, // Effective dissipation code
  output logic [8:0] idiss_us, // Dissipation time in us
  output logic [14:0] idiss_cycles // Dissipation time in cycles
);
  logic rst_meta_reg, rst_n;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic start_det, stop_det, scl_rise, scl_fall;
  hcfg_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg, tx_reg, ptr_reg, rd_data;
  logic oe_reg, drive_low_reg, dev_hit_reg;
  logic wr_en_reg;
  logic skip_fall_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic [7:0] bemf_reg, loop_reg;
  logic [3:0] code_reg, code_next;
  logic [8:0] us_reg, us_next;
  logic [14:0] cyc_reg;
  logic [3:0] ng_pct_reg;
  logic closed_reg, signed_reg;

  // Reset released through two flops so all logic leaves reset together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Bus lines idle high, so the synchronisers reset high
  hcfg_sync #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  // Delayed copies for edge and condition detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    if (ptr_reg == LOOP_CFG_OFFSET) begin
      rd_data = loop_reg; // see [R5]
    end else if (ptr_reg == BEMF_CFG_OFFSET) begin
      rd_data = bemf_reg; // see [R1]
    end
  end

  // Byte engine: address, pointer, then data with auto-increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      dev_hit_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      skip_fall_reg <= 1'b0;
    end else begin
      wr_en_reg <= 1'b0;
      if (start_det) begin
        state_reg <= ST_DEV;
        bit_cnt_reg <= 4'h0;
        oe_reg <= 1'b0;
        // Clock still high here; its next fall precedes the first bit
        skip_fall_reg <= 1'b1;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        oe_reg <= 1'b0;
      end else if (state_reg != ST_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt_reg != ACK_SLOT) begin
            rx_reg <= {rx_reg[6:0], sda_s};
          end else if (state_reg == ST_RD && sda_s) begin
            // Master refused the byte: stop sending until next start
            state_reg <= ST_IDLE;
          end
        end else if (scl_fall && skip_fall_reg) begin
          // Counting this fall would cut the address byte to seven bits
          skip_fall_reg <= 1'b0;
        end else if (scl_fall) begin
          if (bit_cnt_reg < LAST_BIT) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (state_reg == ST_RD) begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= ~tx_reg[6];
            end
          end else if (bit_cnt_reg == LAST_BIT) begin
            bit_cnt_reg <= ACK_SLOT;
            // Acknowledge our own address and every byte received after it, nothing we send
            if (state_reg == ST_DEV) begin
              dev_hit_reg <= (rx_reg[7:1] == DEV_ADDR);
              oe_reg <= (rx_reg[7:1] == DEV_ADDR);
            end else begin
              oe_reg <= (state_reg != ST_RD);
            end
          end else begin
            bit_cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            unique case (state_reg)
              ST_DEV: begin
                if (!dev_hit_reg) begin
                  state_reg <= ST_IDLE;
                end else if (rx_reg[0]) begin
                  state_reg <= ST_RD;
                  tx_reg <= rd_data;
                  oe_reg <= ~rd_data[7];
                  ptr_reg <= ptr_reg + 8'h01;
                end else begin
                  state_reg <= ST_PTR;
                end
              end
              ST_PTR: begin
                ptr_reg <= rx_reg;
                state_reg <= ST_WR;
              end
              ST_WR: begin
                wr_en_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= rx_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
              ST_RD: begin
                tx_reg <= rd_data;
                oe_reg <= ~rd_data[7];
                ptr_reg <= ptr_reg + 8'h01;
              end
              ST_IDLE: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

  // Data pin is open drain: we only ever pull low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_low_reg <= 1'b0;
    end else begin
      drive_low_reg <= 1'b0;
    end
  end

  // Register writes; whole bytes are stored, fields are only views
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bemf_reg <= BEMF_CFG_RESET; // see [R1]
      loop_reg <= LOOP_CFG_RESET; // see [R7]
    end else if (wr_en_reg) begin
      if (wr_addr_reg == LOOP_CFG_OFFSET) begin
        loop_reg <= wr_data_reg; // see [R5]
      end
      if (wr_addr_reg == BEMF_CFG_OFFSET) begin
        bemf_reg <= wr_data_reg; // see [R1]
      end
    end
  end

  // Effective code and time; upper bits only count for resonant drive
  always_comb begin
    if (actuator_type_select) begin
      code_next = {idiss_upper, bemf_reg[IDISS_MSB:IDISS_LSB]}; // see [R2]
      us_next = LRA_IDISS_US[code_next]; // see [R4]
    end else begin
      code_next = {2'b00, bemf_reg[IDISS_MSB:IDISS_LSB]};
      us_next = ERM_IDISS_US[code_next[1:0]]; // see [R3]
    end
  end

  // Decoded timing registered; one cycle behind any change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= 4'h0;
      us_reg <= 9'h000;
      cyc_reg <= 15'h0000;
    end else begin
      code_reg <= code_next;
      us_reg <= us_next;
      // Whole microseconds give an exact count, no rounding needed
      cyc_reg <= CYC_W'(us_next * CLK_MHZ); // see [R3]
    end
  end

  // Decoded loop and format controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ng_pct_reg <= 4'h0;
      closed_reg <= 1'b0;
      signed_reg <= 1'b0;
    end else begin
      ng_pct_reg <= NG_PCT[loop_reg[NG_MSB:NG_LSB]]; // see [R7]
      closed_reg <= !actuator_type_select && !loop_reg[ERM_OPEN_BIT]; // see [R8]
      signed_reg <= !loop_reg[SIGN_FMT_BIT]; // see [R9]
    end
  end

  // Field views straight off the stored registers
  assign sda_o = drive_low_reg;
  assign sda_oe = oe_reg;
  assign back_emf_timing = bemf_reg;
  assign loop_input_cfg = loop_reg;
  assign noise_gate_level = loop_reg[NG_MSB:NG_LSB]; // see [R6]
  assign rotating_mass_loop_open = loop_reg[ERM_OPEN_BIT]; // see [R6]
  assign supply_correction_off = loop_reg[SUPPLY_OFF_BIT]; // see [R6]
  assign live_playback_sign_format = loop_reg[SIGN_FMT_BIT]; // see [R6]
  assign resonant_update_rate = loop_reg[UPDATE_RATE_BIT]; // see [R6]
  assign input_type_select = loop_reg[INPUT_TYPE_BIT]; // see [R6]
  assign noise_gate_pct = ng_pct_reg;
  assign closed_loop_drive = closed_reg;
  assign live_playback_signed = signed_reg;
  assign idiss_code = code_reg;
  assign idiss_us = us_reg;
  assign idiss_cycles = cyc_reg;
endmodule // hcfg_top
`default_nettype wire

// File: verilog/hcfg_pkg.sv
// Constants shared by the haptic timing and loop configuration bank
`default_nettype none
package hcfg_pkg;
  // Register offsets
  localparam logic [7:0] LOOP_CFG_OFFSET = 8'h1d;
  localparam logic [7:0] BEMF_CFG_OFFSET = 8'h1c;
  // Values after reset
  localparam logic [7:0] LOOP_CFG_RESET = 8'h80;
  localparam logic [7:0] BEMF_CFG_RESET = 8'h35;
  // Field positions of the back-EMF timing register
  localparam int IDISS_LSB = 0;
  localparam int IDISS_MSB = 1;
  // Field positions of the loop-and-input register
  localparam int NG_LSB = 6;
  localparam int NG_MSB = 7;
  localparam int ERM_OPEN_BIT = 5;
  localparam int SUPPLY_OFF_BIT = 4;
  localparam int SIGN_FMT_BIT = 3;
  localparam int UPDATE_RATE_BIT = 2;
  localparam int INPUT_TYPE_BIT = 1;
  // Clock rate and derived widths
  localparam int CLK_MHZ = 100;
  localparam int US_W = 9;
  localparam int CYC_W = 15;
  // Dissipation time in microseconds, rotating mass, code 0..3
  localparam logic [8:0] ERM_IDISS_US [4] = '{
    9'h02d, 9'h04b, 9'h096, 9'h0e1};
  // Dissipation time in microseconds, resonant, code 0..15
  localparam logic [8:0] LRA_IDISS_US [16] = '{
    9'h00f, 9'h019, 9'h032, 9'h04b, 9'h05a, 9'h069, 9'h078, 9'h087,
    9'h096, 9'h0a5, 9'h0b4, 9'h0c3, 9'h0d2, 9'h0eb, 9'h104, 9'h11d};
  // Noise-gate threshold in percent per code
  localparam logic [3:0] NG_PCT [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
  // Serial engine
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_PTR  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100
  } hcfg_state_t;
endpackage
`default_nettype wire

// File: verilog/hcfg_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module hcfg_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // hcfg_sync
`default_nettype wire

// File: verification/hcfg_top_sva.sv
// Port assertions for the configuration bank
`default_nettype none
module hcfg_top_sva (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic actuator_type_select, // Type
  input wire logic [1:0] idiss_upper, // Upper code
  input wire logic [7:0] back_emf_timing, // Reg
  input wire logic [7:0] loop_input_cfg, // Reg
  input wire logic [1:0] noise_gate_level, // Field
  input wire logic [3:0] noise_gate_pct, // Percent
  input wire logic rotating_mass_loop_open, // Field
  input wire logic closed_loop_drive, // Derived
  input wire logic supply_correction_off, // Field
  input wire logic live_playback_sign_format, // Field
  input wire logic live_playback_signed, // Derived
  input wire logic resonant_update_rate, // Field
  input wire logic input_type_select, // Field
  input wire logic [3:0] idiss_code, // Code
  input wire logic [8:0] idiss_us // Time
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_reg;
  logic ok;
  // Derived views lag reset release through the synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  assign ok = (up_reg == 3'h7);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Four cycles let the single flop stage of the time decode settle
  sequence s_erm_max;
    (!actuator_type_select && back_emf_timing[1:0] == 2'h3) [*4];
  endsequence
  sequence s_lra_max;
    (actuator_type_select && idiss_upper == 2'h3
      && back_emf_timing[1:0] == 2'h3) [*4];
  endsequence
  a_gate_field: assert property (
    noise_gate_level == loop_input_cfg[7:6]) else $error("gate field");
  a_bit_fields: assert property (
    {rotating_mass_loop_open, supply_correction_off,
     live_playback_sign_format, resonant_update_rate,
     input_type_select} == loop_input_cfg[5:1]) else $error("bit fields");
  a_gate_pct: assert property (ok |=> noise_gate_pct ==
    ($past(noise_gate_level) == 2'h0 ? 4'h0 :
     4'h1 << $past(noise_gate_level))) else $error("gate percent");
  a_closed_loop: assert property (ok |=> closed_loop_drive ==
    !$past(actuator_type_select || rotating_mass_loop_open))
    else $error("closed loop");
  a_sign_fmt: assert property (ok |=> live_playback_signed ==
    !$past(live_playback_sign_format)) else $error("sign format");
  a_code_mux: assert property (ok |=> idiss_code ==
    {$past(actuator_type_select) ? $past(idiss_upper) : 2'h0,
     $past(back_emf_timing[1:0])}) else $error("code mux");
  a_erm_time: assert property (
    s_erm_max |-> idiss_us == 9'h0e1) else $error("erm time");
  a_lra_time: assert property (
    s_lra_max |-> idiss_us == 9'h11d) else $error("lra time");
endmodule // hcfg_top_sva
bind hcfg_top hcfg_top_sva i_sva (
  .clk(clk),
  .arst_n(arst_n),
  .actuator_type_select(actuator_type_select),
  .idiss_upper(idiss_upper),
  .back_emf_timing(back_emf_timing),
  .loop_input_cfg(loop_input_cfg),
  .noise_gate_level(noise_gate_level),
  .noise_gate_pct(noise_gate_pct),
  .rotating_mass_loop_open(rotating_mass_loop_open),
  .closed_loop_drive(closed_loop_drive),
  .supply_correction_off(supply_correction_off),
  .live_playback_sign_format(live_playback_sign_format),
  .live_playback_signed(live_playback_signed),
  .resonant_update_rate(resonant_update_rate),
  .input_type_select(input_type_select),
  .idiss_code(idiss_code),
  .idiss_us(idiss_us)
);
`default_nettype wire

// File: verification/hcfg_host.sv
// Host I2C master model, open-drain on data, no stretching
`default_nettype none
module hcfg_host (
  input wire logic clk, // Clock
  input wire logic sda, // Resolved data line
  output logic scl, // Bus clock
  output logic sda_low // Pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Third of a bit; SCL high stays well above four clocks
  task automatic hp;
    repeat (12) @(posedge clk);
    #1;
  endtask
  // Data only moves while SCL is low, after a hold gap
  task automatic bit_io(input logic b, output logic r);
    hp;
    sda_low = !b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start;
    hp;
    sda_low = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  task automatic stop;
    hp;
    sda_low = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b0;
    hp;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Single byte reads only, so the master always answers NACK
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, v,
                    output logic [2:0] k);
    start;
    put({a, 1'b0}, k[2]);
    put(p, k[1]);
    put(v, k[0]);
    stop;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [7:0] d, output logic [2:0] k);
    start;
    put({a, 1'b0}, k[2]);
    put(p, k[1]);
    start;
    put({a, 1'b1}, k[0]);
    get(d);
    stop;
  endtask
endmodule // hcfg_host
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the configuration bank
`default_nettype none
module testbench import hcfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADR = 7'h2a;
  localparam logic [8:0] ERM_T [4] = '{9'h02d, 9'h04b, 9'h096, 9'h0e1};
  localparam logic [8:0] LRA_T [16] = '{9'h00f, 9'h019, 9'h032, 9'h04b,
    9'h05a, 9'h069, 9'h078, 9'h087, 9'h096, 9'h0a5, 9'h0b4, 9'h0c3,
    9'h0d2, 9'h0eb, 9'h104, 9'h11d};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic actuator_type_select = 1'b0;
  logic [1:0] idiss_upper = 2'h0;
  logic scl, host_low, sda, sda_oe;
  logic [7:0] back_emf_timing, loop_input_cfg;
  logic [1:0] noise_gate_level;
  logic [3:0] noise_gate_pct, idiss_code;
  logic rotating_mass_loop_open, closed_loop_drive, supply_correction_off;
  logic live_playback_sign_format, live_playback_signed;
  logic resonant_update_rate, input_type_select;
  logic [8:0] idiss_us;
  logic [14:0] idiss_cycles;
  int failures = 0;
  int check_count = 0;
  // Pull-up on data: low while either side pulls
  assign sda = !(host_low || sda_oe);
  initial forever #5 clk = ~clk;
  hcfg_top #(.DEV_ADDR(ADR)) i_dut (
    .clk(clk),
    .arst_n(arst_n),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(),
    .sda_oe(sda_oe),
    .actuator_type_select(actuator_type_select),
    .idiss_upper(idiss_upper),
    .back_emf_timing(back_emf_timing),
    .loop_input_cfg(loop_input_cfg),
    .noise_gate_level(noise_gate_level),
    .noise_gate_pct(noise_gate_pct),
    .rotating_mass_loop_open(rotating_mass_loop_open),
    .closed_loop_drive(closed_loop_drive),
    .supply_correction_off(supply_correction_off),
    .live_playback_sign_format(live_playback_sign_format),
    .live_playback_signed(live_playback_signed),
    .resonant_update_rate(resonant_update_rate),
    .input_type_select(input_type_select),
    .idiss_code(idiss_code),
    .idiss_us(idiss_us),
    .idiss_cycles(idiss_cycles)
  );
  hcfg_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task automatic chk(input logic [15:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] p, v);
    logic [2:0] k;
    i_host.wr(ADR, p, v, k);
    chk(k, 3'h7, "write ack");
  endtask
  task automatic rreg(input logic [7:0] p, output logic [7:0] d);
    logic [2:0] k;
    i_host.rd(ADR, p, d, k);
    chk(k, 3'h7, "read ack");
  endtask
  task automatic wt;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well past the few hundred microseconds of traffic
  initial begin
    #600000;
    failures++;
    end_sim;
  end
  initial begin
    logic [7:0] d, v;
    logic [2:0] k;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    wt;
    rreg(BEMF_CFG_OFFSET, d);
    chk(d[1:0], 2'h1, "idiss reset");
    rreg(LOOP_CFG_OFFSET, d);
    chk(d, 8'h80, "loop reset");
    chk(noise_gate_pct, 4'h4, "pct reset");
    chk(idiss_us, 9'h04b, "time reset");
    $display("reset test done");
    // Each field bit takes both values across the four gate codes
    for (int c = 0; c < 4; c++) begin
      v = {c[1:0], 6'h2a ^ {6{c[0]}}};
      wreg(LOOP_CFG_OFFSET, v);
      rreg(LOOP_CFG_OFFSET, d);
      chk(d, v, "loop readback");
      chk(loop_input_cfg[7:1], v[7:1], "fields");
      chk(noise_gate_pct, c == 0 ? 4'h0 : 4'h1 << c, "pct");
      chk(closed_loop_drive, !v[5], "closed");
      chk(live_playback_signed, !v[3], "signed");
    end
    $display("loop test done");
    // Upper bits must be ignored for a rotating mass
    idiss_upper = 2'h3;
    for (int c = 0; c < 4; c++) begin
      wreg(BEMF_CFG_OFFSET, {6'h0d, c[1:0]});
      rreg(BEMF_CFG_OFFSET, d);
      chk(d, {6'h0d, c[1:0]}, "bemf readback");
      chk(back_emf_timing, {6'h0d, c[1:0]}, "bemf out");
      chk(idiss_code, c, "erm code");
      chk(idiss_us, ERM_T[c], "erm time");
      chk(idiss_cycles, ERM_T[c] * 16'h64, "erm cycles");
    end
    $display("erm test done");
    actuator_type_select = 1'b1;
    for (int lo = 0; lo < 4; lo++) begin
      wreg(BEMF_CFG_OFFSET, {6'h00, lo[1:0]});
      for (int hi = 0; hi < 4; hi++) begin
        idiss_upper = hi[1:0];
        wt;
        chk(idiss_code, hi * 4 + lo, "lra code");
        chk(idiss_us, LRA_T[hi * 4 + lo], "lra time");
      end
    end
    chk(closed_loop_drive, 1'b0, "resonant closed");
    $display("lra test done");
    i_host.wr(ADR ^ 7'h01, LOOP_CFG_OFFSET, 8'h00, k);
    chk(k, 3'h0, "foreign nack");
    rreg(8'h1e, d);
    chk(d, 8'h00, "unmapped read");
    rreg(LOOP_CFG_OFFSET, d);
    chk(d, 8'hd5, "loop kept");
    $display("refusal test done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
